// File: hw/sdm_cfg.svh
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH

// Register byte offsets
`define SDM_OFS_CTRL 8'h00
`define SDM_OFS_DELAY 8'h04
`define SDM_OFS_STATUS 8'h08
`define SDM_OFS_INT_STAT 8'h0C
`define SDM_OFS_INT_MASK 8'h10
`define SDM_OFS_CMD 8'h14

// Field positions and widths
`define SDM_MODE_W 3
`define SDM_DELAY_W 8
`define SDM_EVT_W 5
`define SDM_ST_TRIP 3
`define SDM_ST_FAULT 4
`define SDM_ST_FSC 5
`define SDM_ST_LOCK 6
`define SDM_ST_SKEW 7
`define SDM_CMD_CLEAR 0

// Reset values
`define SDM_RST_MODE 3'h0
`define SDM_RST_DELAY 8'h00
`define SDM_RST_MASK 5'h00

// Timing: judgement period and allowance in 10 ms units
`define SDM_CLK_HZ 20000000
`define SDM_JUDGE_MS 10
`define SDM_DELAY_MAX_S 2
`define SDM_DELAY_MAX (`SDM_DELAY_MAX_S * 1000 / `SDM_JUDGE_MS)
`define SDM_TICK_CYCLES (`SDM_CLK_HZ / 1000 * `SDM_JUDGE_MS)
`endif

// File: hw/sdm_pkg.sv
package sdm_pkg;
  // Combined contact class
  typedef enum logic [2:0] {
    CLS_BOTH_CLOSED = 3'h1,
    CLS_A_OPEN = 3'h2,
    CLS_B_OPEN = 3'h3,
    CLS_BOTH_OPEN = 3'h4,
    CLS_FAULT = 3'h5
  } sdm_class_t;

  // Monitoring mode selection
  typedef enum logic [2:0] {
    MODE_NONE = 3'h0,
    MODE_SHUT_TRIP = 3'h1,
    MODE_MISMATCH_TRIP = 3'h2,
    MODE_DISPLAY_A = 3'h3,
    MODE_DISPLAY_B = 3'h4,
    MODE_DELAY_LOCK = 3'h5,
    MODE_DELAY_WATCH = 3'h6,
    MODE_SPARE = 3'h7
  } sdm_mode_t;

  // Restoration tracker, one-hot
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SHUT = 4'h2,
    ST_SKEW = 4'h4,
    ST_LOCK = 4'h8
  } sdm_state_t;
endpackage

// File: hw/sdm_evt_if.sv
interface sdm_evt_if;
  import sdm_pkg::*;
  sdm_class_t cls;
  logic ev_both_closed;
  logic ev_one_open;
  logic ev_fault;
  logic ev_both_open;
  modport src (output cls, ev_both_closed, ev_one_open, ev_fault, ev_both_open);
  modport dst (input cls, ev_both_closed, ev_one_open, ev_fault, ev_both_open);
endinterface

// File: hw/sdm_classifier.sv
module sdm_classifier
  import sdm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_contact_a,
  input wire logic i_contact_b,
  input wire logic i_fault,
  sdm_evt_if.src o_evt
);
  logic a_meta_q, a_q, b_meta_q, b_q;
  sdm_class_t cls_q, cls_d;
  logic changed;
  logic ev_bc_q, ev_oo_q, ev_f_q, ev_bo_q;

  // Two-stage synchronisers; only the second stage is decoded
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      a_meta_q <= 1'b0;
      a_q <= 1'b0;
      b_meta_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_meta_q <= i_contact_a;
      a_q <= a_meta_q;
      b_meta_q <= i_contact_b;
      b_q <= b_meta_q;
    end
  end

  // Failure overrides the contact levels; high means closed
  assign cls_d = i_fault ? CLS_FAULT :
                 (a_q && b_q) ? CLS_BOTH_CLOSED :
                 (!a_q && b_q) ? CLS_A_OPEN :
                 (a_q && !b_q) ? CLS_B_OPEN : CLS_BOTH_OPEN;
  assign changed = (cls_d != cls_q);

  // Events are one-cycle pulses on entry to a class
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cls_q <= CLS_BOTH_OPEN;
      ev_bc_q <= 1'b0;
      ev_oo_q <= 1'b0;
      ev_f_q <= 1'b0;
      ev_bo_q <= 1'b0;
    end else begin
      cls_q <= cls_d;
      ev_bc_q <= changed && (cls_d == CLS_BOTH_CLOSED);
      ev_oo_q <= changed && (cls_d == CLS_A_OPEN || cls_d == CLS_B_OPEN);
      ev_f_q <= changed && (cls_d == CLS_FAULT);
      ev_bo_q <= changed && (cls_d == CLS_BOTH_OPEN);
    end
  end

  assign o_evt.cls = cls_q;
  assign o_evt.ev_both_closed = ev_bc_q;
  assign o_evt.ev_one_open = ev_oo_q;
  assign o_evt.ev_fault = ev_f_q;
  assign o_evt.ev_both_open = ev_bo_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // Class follows steady contacts three edges later, a failure input one edge later
  a_sync_closed: assert property ((!i_fault && i_contact_a && i_contact_b)[*3] |=>
    cls_q == CLS_BOTH_CLOSED) else $error("both closed not classified");
  a_sync_a_open: assert property ((!i_fault && !i_contact_a && i_contact_b)[*3] |=>
    cls_q == CLS_A_OPEN) else $error("contact A open not classified");
  a_oneside_entry: assert property (ev_oo_q |->
    (cls_q == CLS_A_OPEN || cls_q == CLS_B_OPEN) && $past(cls_q) != cls_q)
    else $error("mismatch event without entry");
  a_fault_class: assert property (i_fault |=> cls_q == CLS_FAULT)
    else $error("failure not classified");
endmodule

// File: hw/sdm_monitor.sv
`include "sdm_cfg.svh"

module sdm_monitor
  import sdm_pkg::*;
#(
  parameter int TICK_CYCLES = `SDM_TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_safety_contact_a,
  input wire logic i_safety_contact_b,
  input wire logic i_internal_fault_detect,
  input wire logic i_trip_clear_input,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_input_discrepancy_output,
  output logic o_trip_alarm_indicator,
  output logic o_internal_fault_trip,
  output logic o_irq
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [7:0] DELAY_MAX = 8'(`SDM_DELAY_MAX);

  sdm_evt_if evt ();

  sdm_classifier u_cls (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_contact_a(i_safety_contact_a),
    .i_contact_b(i_safety_contact_b),
    .i_fault(i_internal_fault_detect),
    .o_evt(evt)
  );

  // ---- AHB-Lite slave ----
  logic [2:0] mode_q;
  logic [7:0] delay_q;
  logic [4:0] int_stat_q, int_stat_d, int_mask_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic hready_q;
  logic addr_ok, rd_take, wr_take;
  logic wr_ctrl, wr_delay, wr_istat, wr_imask, wr_cmd;
  logic [31:0] rd_mux, status_word;
  logic [7:0] delay_wr;

  // Address phase decode; only word transfers are mapped
  assign addr_ok = i_hsel && i_htrans[1] && i_hready && (i_hsize == 3'h2);
  assign rd_take = addr_ok && !i_hwrite;
  assign wr_take = addr_ok && i_hwrite;
  assign wr_ctrl = wr_pend_q && (wr_addr_q == `SDM_OFS_CTRL);
  assign wr_delay = wr_pend_q && (wr_addr_q == `SDM_OFS_DELAY);
  assign wr_istat = wr_pend_q && (wr_addr_q == `SDM_OFS_INT_STAT);
  assign wr_imask = wr_pend_q && (wr_addr_q == `SDM_OFS_INT_MASK);
  assign wr_cmd = wr_pend_q && (wr_addr_q == `SDM_OFS_CMD);
  // Out-of-range allowance clamps to 2.00 s rather than wrapping
  assign delay_wr = (i_hwdata[7:0] > DELAY_MAX) ? DELAY_MAX : i_hwdata[7:0];

  // Bus handshake state; zero wait states, always OKAY
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= {i_haddr[7:2], 2'b00};
      hready_q <= 1'b1;
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Software-owned configuration
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_q <= `SDM_RST_MODE;
      delay_q <= `SDM_RST_DELAY;
      int_mask_q <= `SDM_RST_MASK;
    end else begin
      if (wr_ctrl) begin
        mode_q <= i_hwdata[`SDM_MODE_W-1:0];
      end
      if (wr_delay) begin
        delay_q <= delay_wr;
      end
      if (wr_imask) begin
        int_mask_q <= i_hwdata[`SDM_EVT_W-1:0];
      end
    end
  end

  // ---- Judgement tick divider ----
  logic [TW-1:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  // ---- Release skew timer and restoration tracker ----
  sdm_state_t state_q, state_d;
  logic [7:0] skew_cnt_q;
  logic one_side, mode_lock, mode_56, ev_timeout, lockout, skewing;
  assign one_side = (evt.cls == CLS_A_OPEN) || (evt.cls == CLS_B_OPEN);
  assign mode_lock = (mode_q == MODE_DELAY_LOCK);
  assign mode_56 = mode_lock || (mode_q == MODE_DELAY_WATCH);
  assign lockout = (state_q == ST_LOCK);
  assign skewing = (state_q == ST_SKEW);
  // Fires once: the tracker leaves ST_SKEW on the same edge
  assign ev_timeout = mode_lock && skewing && one_side && (skew_cnt_q > delay_q);

  // Counts whole ticks; resolution is one judgement period
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !skewing || evt.ev_one_open) begin
      skew_cnt_q <= 8'h00;
    end else if (tick && skew_cnt_q != 8'hFF) begin
      skew_cnt_q <= skew_cnt_q + 8'h01;
    end
  end

  // Lockout is left only through the both-open class
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (evt.ev_one_open) state_d = ST_SKEW;
        else if (evt.ev_both_open) state_d = ST_SHUT;
      end
      ST_SHUT: begin
        if (evt.ev_one_open) state_d = ST_SKEW;
        else if (evt.ev_both_closed) state_d = ST_RUN;
      end
      ST_SKEW: begin
        if (ev_timeout) state_d = ST_LOCK;
        else if (evt.ev_both_open) state_d = ST_SHUT;
        else if (evt.ev_both_closed) state_d = ST_RUN;
      end
      ST_LOCK: begin
        if (evt.ev_both_open) state_d = ST_SHUT;
      end
      default: state_d = ST_SHUT;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= ST_SHUT;
    end else begin
      state_q <= state_d;
    end
  end

  // ---- Trips ----
  logic trip_q, fault_q, clr_pin_q, clr_req;
  logic trip_set, trip_clr;
  // Trip clear acts on the release of the clear pin, or a command write
  assign clr_req = (clr_pin_q && !i_trip_clear_input) ||
                   (wr_cmd && i_hwdata[`SDM_CMD_CLEAR]);
  assign trip_set = ((mode_q == MODE_SHUT_TRIP) && (evt.ev_one_open || evt.ev_both_open)) ||
                    ((mode_q == MODE_MISMATCH_TRIP) && evt.ev_one_open) ||
                    ev_timeout;
  // A locked-out drive refuses the clear until both contacts open
  assign trip_clr = clr_req && !lockout && !ev_timeout;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      trip_q <= 1'b0;
      fault_q <= 1'b0;
      clr_pin_q <= 1'b0;
    end else begin
      clr_pin_q <= i_trip_clear_input;
      if (trip_set) begin
        trip_q <= 1'b1;
      end else if (trip_clr) begin
        trip_q <= 1'b0;
      end
      // Only the power-on reset above releases this trip
      if (evt.cls == CLS_FAULT) begin
        fault_q <= 1'b1;
      end
    end
  end

  // ---- Discrepancy output, sampled at the judgement tick ----
  logic fsc_q, fsc_d;
  assign fsc_d = !(trip_q || fault_q || (mode_56 && (skewing || lockout)));

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fsc_q <= 1'b1;
    end else if (tick) begin
      fsc_q <= fsc_d;
    end
  end

  // ---- Sticky events: set wins over write-one-clear ----
  logic [4:0] ev_vec, istat_clr;
  logic irq_q, alarm_q;
  assign ev_vec = {ev_timeout, evt.ev_both_open, evt.ev_fault, evt.ev_one_open,
                   evt.ev_both_closed};
  assign istat_clr = wr_istat ? i_hwdata[`SDM_EVT_W-1:0] : 5'h00;
  assign int_stat_d = (int_stat_q & ~istat_clr) | ev_vec;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      int_stat_q <= 5'h00;
      irq_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      irq_q <= |(int_stat_q & int_mask_q);
      alarm_q <= trip_q || fault_q;
    end
  end

  // ---- Read mux; unmapped reads return zero ----
  // Trip at bit 3 upward, packed directly above the class field
  assign status_word = {24'h00_0000, skewing, lockout, fsc_q, fault_q, trip_q, evt.cls};
  assign rd_mux = (i_haddr[7:0] == `SDM_OFS_CTRL) ? {29'h0000_0000, mode_q} :
                  (i_haddr[7:0] == `SDM_OFS_DELAY) ? {24'h00_0000, delay_q} :
                  (i_haddr[7:0] == `SDM_OFS_STATUS) ? status_word :
                  (i_haddr[7:0] == `SDM_OFS_INT_STAT) ? {27'h000_0000, int_stat_q} :
                  (i_haddr[7:0] == `SDM_OFS_INT_MASK) ? {27'h000_0000, int_mask_q} :
                  32'h0000_0000;

  assign o_hrdata = rdata_q;
  assign o_hreadyout = hready_q;
  assign o_hresp = 1'b0;
  assign o_input_discrepancy_output = fsc_q;
  assign o_trip_alarm_indicator = alarm_q;
  assign o_internal_fault_trip = fault_q;
  assign o_irq = irq_q;

  // ---- Checks ----
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_timeout_fired;
    ev_timeout;
  endsequence

  sequence s_clear_in_lock;
    lockout && clr_req && !evt.ev_both_open;
  endsequence

  a_fault_sticky: assert property (fault_q |=> fault_q)
    else $error("internal fault trip dropped without reset");
  // Alarm register trails the trip by one cycle
  a_fault_latch: assert property (evt.cls == CLS_FAULT |=> fault_q ##1 alarm_q)
    else $error("failure class did not trip");
  a_timeout_mode: assert property (ev_timeout |-> mode_q == MODE_DELAY_LOCK)
    else $error("timeout outside mode 05");
  a_timeout_late: assert property (ev_timeout |-> skew_cnt_q > delay_q && one_side)
    else $error("timeout before allowance");
  a_lock_entry: assert property (s_timeout_fired |=> lockout && trip_q ##1 alarm_q)
    else $error("timeout did not lock out");
  a_lock_refuse: assert property (s_clear_in_lock |=> trip_q)
    else $error("trip cleared during lockout");
  a_fsc_hold: assert property (!tick |=> $stable(fsc_q))
    else $error("discrepancy output moved between ticks");
  a_fsc_off_trip: assert property (tick && (trip_q || fault_q) |=> !fsc_q)
    else $error("discrepancy output active under trip");
  a_fsc_off_skew: assert property (tick && mode_56 && skewing |=> !fsc_q)
    else $error("discrepancy output active during delay");
  a_fsc_on_other: assert property (tick && !mode_56 && !trip_q && !fault_q |=> fsc_q)
    else $error("discrepancy output inactive without trip");
  // Bit may only drop after a write-one-clear that names it
  a_mismatch_flag: assert property (evt.ev_one_open |=> int_stat_q[1] ##1
    (int_stat_q[1] || $past(wr_istat && i_hwdata[1])))
    else $error("mismatch event lost");
  a_shut_flag: assert property (evt.ev_both_open |=> int_stat_q[3])
    else $error("shut-off event lost");
  a_irq_level: assert property (|(int_stat_q & int_mask_q) |=> o_irq)
    else $error("unmasked status without interrupt");
  a_closed_flag: assert property (evt.ev_both_closed |=> int_stat_q[0])
    else $error("both-closed event lost");
  a_fail_flag: assert property (evt.ev_fault |=> int_stat_q[2])
    else $error("failure event lost");
  a_timeout_flag: assert property (s_timeout_fired |=> int_stat_q[4])
    else $error("timeout event lost");
  // A stored allowance beyond 2.00 s would stretch the lockout window
  a_delay_clamp: assert property (wr_delay |=> delay_q <= DELAY_MAX)
    else $error("allowance above limit");
  a_lock_exit: assert property (lockout && evt.ev_both_open |=> state_q == ST_SHUT)
    else $error("lockout kept after both open");
endmodule

// File: sim/sdm_contacts.sv
// Relay pair and failure detector; relays hold their level, so no release value
module sdm_contacts (
  input wire logic i_sys_clk,
  input wire logic i_want_a,
  input wire logic i_want_b,
  input wire logic i_want_fault,
  input wire logic [1:0] i_lag,
  output logic o_contact_a,
  output logic o_contact_b,
  output logic o_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] sa = 4'h0;
  logic [3:0] sb = 4'h0;
  logic [3:0] sf = 4'h0;
  // Slow relays answer one to four cycles late, same lag on both poles
  always @(posedge i_sys_clk) begin
    sa <= {sa[2:0], i_want_a};
    sb <= {sb[2:0], i_want_b};
    sf <= {sf[2:0], i_want_fault};
  end
  assign o_contact_a = sa[i_lag];
  assign o_contact_b = sb[i_lag];
  assign o_fault = sf[i_lag];
endmodule

// File: sim/sdm_monitor_bench.sv
module sdm_monitor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  logic clk = 1'b0, rst = 1'b1, wa = 1'b0, wb = 1'b0, wf = 1'b0, clr = 1'b0;
  logic [1:0] lag = 2'h0;
  logic ca, cb, cf, hsel = 1'b0, hwrite = 1'b0, rdy, hresp, disc, alarm, ftrip, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  int miscompares = 0, cmp_count = 0, cyc = 0, last = 0, have = 0;
  logic disc_prev = 1'b1;
  always #25 clk = ~clk;
  sdm_contacts u_far (.i_sys_clk(clk), .i_want_a(wa), .i_want_b(wb), .i_want_fault(wf),
    .i_lag(lag), .o_contact_a(ca), .o_contact_b(cb), .o_fault(cf));
  sdm_monitor #(.TICK_CYCLES(TK)) u_dut (.i_sys_clk(clk), .i_rst(rst),
    .i_safety_contact_a(ca), .i_safety_contact_b(cb), .i_internal_fault_detect(cf),
    .i_trip_clear_input(clr), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
    .o_hreadyout(rdy), .o_hresp(hresp), .o_input_discrepancy_output(disc),
    .o_trip_alarm_indicator(alarm), .o_internal_fault_trip(ftrip), .o_irq(irq));
  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t pin %b expected %b", $time, got, exp);
    end
  endtask
  // One single transfer; read data taken at the data-phase end edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    r = hrdata;
  endtask
  // Model class from contact levels (high = closed)
  function automatic logic [31:0] cls(input logic a, input logic b, input logic f);
    return f ? 32'h5 : (a && b) ? 32'h1 : (!a && b) ? 32'h2 : (a && !b) ? 32'h3 : 32'h4;
  endfunction
  task automatic put(input logic a, input logic b);
    wa <= a; wb <= b;
    repeat (8) @(posedge clk);
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
  endtask
  task automatic clear_trip();
    bus(1'b1, 8'h14, 32'h1);
    clr <= 1'b1;
    repeat (2) @(posedge clk);
    clr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Output may move only on judgement ticks, so changes sit whole periods apart
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      report_and_stop();
    end
    if (rst) have = 0;
    else if (disc !== disc_prev) begin
      if (have) chk_reg((cyc - last) % TK, 32'h0);
      last = cyc; have = 1;
    end
    disc_prev = disc;
  end
  initial begin
    void'($urandom(32'h63DA2E29));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 8'h08, 0); chk_reg(r, 32'h24);
    bus(1'b0, 8'h10, 0); chk_reg(r, 32'h0);
    chk_pin(hresp, 1'b0);
    bus(1'b1, 8'h04, 32'hFF); bus(1'b0, 8'h04, 0); chk_reg(r, 32'hC8);
    bus(1'b0, 8'h40, 0); chk_reg(r, 32'h0);
    // Both-closed, one-open and both-open entries with their event bits; irq follows the mask
    put(1, 1); bus(1'b0, 8'h0C, 0); chk_reg(r, 32'h1); chk_pin(irq, 1'b0);
    bus(1'b1, 8'h10, 32'h1F); repeat (2) @(posedge clk); chk_pin(irq, 1'b1);
    bus(1'b1, 8'h0C, 32'h1F); repeat (2) @(posedge clk); chk_pin(irq, 1'b0);
    put(0, 1); bus(1'b0, 8'h0C, 0); chk_reg(r, 32'h2);
    bus(1'b1, 8'h0C, 32'h1F); put(1, 0); bus(1'b0, 8'h0C, 0); chk_reg(r, 32'h2);
    put(0, 0); bus(1'b0, 8'h0C, 0); chk_reg(r, 32'hA);
    // Every mode: one pole opens from run, then trip and discrepancy output
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h00, m); put(1, 1); clear_trip(); ticks(2);
      chk_pin(disc, 1'b1);
      put(0, 1); ticks(2);
      chk_pin(alarm, m == 1 || m == 2);
      chk_pin(disc, !(m == 1 || m == 2 || m == 5 || m == 6));
      put(0, 0); clear_trip(); ticks(2); chk_pin(alarm, 1'b0);
    end
    // Release held one-sided too long; only mode 05 locks out
    bus(1'b1, 8'h04, 32'h1);
    for (int m = 5; m < 7; m++) begin
      bus(1'b1, 8'h00, m); bus(1'b1, 8'h0C, 32'h1F); put(0, 0);
      put(1, 0); ticks(4);
      bus(1'b0, 8'h0C, 0); chk_reg(r[4], m == 5);
      chk_pin(alarm, m == 5);
      put(1, 1); clear_trip(); chk_pin(alarm, m == 5);
      put(0, 0); clear_trip(); chk_pin(alarm, 1'b0);
    end
    // Random contact pairs, slow or prompt relays
    for (int i = 0; i < 16; i++) begin
      lag <= 2'($urandom_range(3));
      put(1'($urandom), 1'($urandom));
      bus(1'b0, 8'h08, 0); chk_reg({29'h0, r[2:0]}, cls(wa, wb, 1'b0));
    end
    // Internal failure survives both trip clears, leaves only at reset
    bus(1'b1, 8'h0C, 32'h1F); wf <= 1'b1; put(1, 1);
    bus(1'b0, 8'h08, 0); chk_reg({29'h0, r[2:0]}, cls(1, 1, 1));
    bus(1'b0, 8'h0C, 0); chk_reg(r[2], 1'b1);
    wf <= 1'b0; put(1, 1); clear_trip(); ticks(1);
    chk_pin(ftrip, 1'b1); chk_pin(alarm, 1'b1); chk_pin(disc, 1'b0);
    rst <= 1'b1; repeat (4) @(posedge clk); rst <= 1'b0; @(posedge clk); #1;
    chk_pin(ftrip, 1'b0); chk_pin(alarm, 1'b0); chk_pin(disc, 1'b1);
    report_and_stop();
  end
endmodule
